// File: logic/pskm_host.sv
// keyboard/mouse host: link capture, framing, command sender, decoders
`timescale 1ns/1ns
module pskm_host #(
    parameter int TX_WAIT_CYC = pskm_pkg::TX_WAIT_US * 1000 / pskm_pkg::CLK_PERIOD_NS
) (
    input  wire logic                 I_MCLK,
    input  wire logic                 I_RESET_N,
    input  wire logic                 I_KM_CLK,
    input  wire logic                 I_KM_DATA,
    output logic                      O_KM_CLK_OUT,
    output logic                      O_KM_CLK_OE,
    output logic                      O_KM_DATA_OUT,
    output logic                      O_KM_DATA_OE,
    input  wire logic                 I_MOUSE_MODE,
    input  wire logic                 I_INHIBIT,
    input  wire logic                 I_CMD_VALID,
    input  wire pskm_pkg::pskm_cmd_t  I_CMD,
    output logic                      O_CMD_READY,
    output logic                      O_CMD_DONE,
    output logic                      O_CMD_NACK,
    output logic                      O_RX_VALID,
    output logic [7:0]                O_RX_BYTE,
    output logic                      O_RX_ERROR,
    output logic                      O_KEY_VALID,
    output pskm_pkg::pskm_key_t       O_KEY,
    output logic                      O_MOUSE_VALID,
    output pskm_pkg::pskm_mouse_t     O_MOUSE,
    output logic                      O_BUSY
);
    localparam int TMR_W = pskm_pkg::TMR_W;

    // ---------------- link clock domain ----------------
    logic link_bit_reg;
    logic link_bit_next;
    logic link_tog_reg;
    logic link_tog_next;

    // each falling edge latches the data line and flips an event toggle
    always_comb begin
        link_bit_next = I_KM_DATA;
        link_tog_next = ~link_tog_reg;
    end

    // data is read while the clock is low, never on the high phase
    always_ff @(negedge I_KM_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            link_bit_reg <= 1'b1;
            link_tog_reg <= 1'b0;
        end else begin
            link_bit_reg <= link_bit_next;
            link_tog_reg <= link_tog_next;
        end
    end

    // ---------------- crossing into the system clock ----------------
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_s3_reg;
    logic kclk_s1_reg;
    logic kclk_s2_reg;
    logic edge_ev;

    // link_bit_reg is stable ~30 us after the toggle, so it is read directly
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            tog_s1_reg  <= 1'b0;
            tog_s2_reg  <= 1'b0;
            tog_s3_reg  <= 1'b0;
            kclk_s1_reg <= 1'b1;
            kclk_s2_reg <= 1'b1;
        end else begin
            tog_s1_reg  <= link_tog_reg;
            tog_s2_reg  <= tog_s1_reg;
            tog_s3_reg  <= tog_s2_reg;
            kclk_s1_reg <= I_KM_CLK;
            kclk_s2_reg <= kclk_s1_reg;
        end
    end

    assign edge_ev = tog_s2_reg ^ tog_s3_reg;

    // ---------------- frame engine and command sender ----------------
    pskm_pkg::pskm_state_t st_reg;
    pskm_pkg::pskm_state_t st_next;
    logic [TMR_W-1:0]      tmr_reg;
    logic [TMR_W-1:0]      tmr_next;
    logic [3:0]            bitcnt_reg;
    logic [3:0]            bitcnt_next;
    logic [7:0]            sh_reg;
    logic [7:0]            sh_next;
    logic                  par_reg;
    logic                  par_next;
    logic [7:0]            tx_byte_reg;
    logic [7:0]            tx_byte_next;
    logic [7:0]            second_reg;
    logic [7:0]            second_next;
    logic                  need2_reg;
    logic                  need2_next;
    logic                  await_reg;
    logic                  await_next;
    logic                  clk_oe_reg;
    logic                  clk_oe_next;
    logic                  data_oe_reg;
    logic                  data_oe_next;
    logic                  rx_valid_reg;
    logic                  rx_valid_next;
    logic                  rx_resp_reg;
    logic                  rx_resp_next;
    logic                  rx_err_reg;
    logic                  rx_err_next;
    logic                  rx_abort_reg;
    logic                  rx_abort_next;
    logic [7:0]            rx_byte_reg;
    logic [7:0]            rx_byte_next;
    logic                  done_reg;
    logic                  done_next;
    logic                  nack_reg;
    logic                  nack_next;
    logic                  cmd_take;
    logic                  frame_ok;

    assign O_CMD_READY = (st_reg == pskm_pkg::ST_IDLE) && !await_reg && !I_INHIBIT && !edge_ev;
    assign cmd_take    = I_CMD_VALID && O_CMD_READY;
    assign frame_ok    = link_bit_reg && (^{sh_reg, par_reg});

    // next state of the frame engine
    always_comb begin
        st_next       = st_reg;
        tmr_next      = tmr_reg + {{(TMR_W-1){1'b0}}, 1'b1};
        bitcnt_next   = bitcnt_reg;
        sh_next       = sh_reg;
        par_next      = par_reg;
        tx_byte_next  = tx_byte_reg;
        second_next   = second_reg;
        need2_next    = need2_reg;
        await_next    = await_reg;
        clk_oe_next   = clk_oe_reg;
        data_oe_next  = data_oe_reg;
        rx_valid_next = 1'b0;
        rx_resp_next  = rx_resp_reg;
        rx_err_next   = 1'b0;
        rx_abort_next = 1'b0;
        rx_byte_next  = rx_byte_reg;
        done_next     = 1'b0;
        nack_next     = 1'b0;
        if (edge_ev) begin
            tmr_next = '0;
        end
        case (st_reg)
            pskm_pkg::ST_IDLE: begin
                tmr_next     = '0;
                clk_oe_next  = I_INHIBIT;
                data_oe_next = 1'b0;
                if (edge_ev && !link_bit_reg) begin
                    st_next     = pskm_pkg::ST_RX;
                    bitcnt_next = pskm_pkg::BIT_FIRST_DATA;
                end else if (cmd_take) begin
                    st_next      = pskm_pkg::ST_RTS;
                    tx_byte_next = I_CMD.op;
                    need2_next   = (I_CMD.op == pskm_pkg::CMD_LEDS) ||
                                   (I_CMD.op == pskm_pkg::CMD_RATE);
                    // upper led bits are ignored by the keyboard, send zeros
                    if (I_CMD.op == pskm_pkg::CMD_LEDS) begin
                        second_next = {5'h00, I_CMD.arg[pskm_pkg::LED_W-1:0]};
                    end else begin
                        second_next = I_CMD.arg;
                    end
                end
            end
            pskm_pkg::ST_RX: begin
                if (edge_ev) begin
                    bitcnt_next = bitcnt_reg + 4'h1;
                    if (bitcnt_reg <= pskm_pkg::BIT_LAST_DATA) begin
                        sh_next = {link_bit_reg, sh_reg[7:1]};
                    end else if (bitcnt_reg == pskm_pkg::BIT_PARITY) begin
                        par_next = link_bit_reg;
                    end else begin
                        st_next = pskm_pkg::ST_IDLE;
                        if (!frame_ok) begin
                            rx_err_next = 1'b1;
                        end else begin
                            rx_valid_next = 1'b1;
                            rx_byte_next  = sh_reg;
                            rx_resp_next  = await_reg;
                            if (await_reg) begin
                                await_next = 1'b0;
                                if (sh_reg == pskm_pkg::RSP_ACK) begin
                                    st_next      = pskm_pkg::ST_RTS;
                                    tx_byte_next = second_reg;
                                    need2_next   = 1'b0;
                                    tmr_next     = '0;
                                end else begin
                                    nack_next = 1'b1;
                                end
                            end
                        end
                    end
                end else if (kclk_s2_reg && tmr_reg >= TMR_W'(pskm_pkg::RX_TO_CYC - 1)) begin
                    // only a clock parked high counts as a stalled word
                    st_next       = pskm_pkg::ST_IDLE;
                    rx_abort_next = 1'b1;
                end
            end
            pskm_pkg::ST_RTS: begin
                clk_oe_next = 1'b1;
                // data goes low one cycle before the clock is let go
                if (tmr_reg == TMR_W'(pskm_pkg::RTS_CYC - 1)) begin
                    data_oe_next = 1'b1;
                end
                if (tmr_reg == TMR_W'(pskm_pkg::RTS_CYC)) begin
                    st_next     = pskm_pkg::ST_TX;
                    clk_oe_next = 1'b0;
                    bitcnt_next = 4'h0;
                    tmr_next    = '0;
                end
            end
            pskm_pkg::ST_TX: begin
                if (edge_ev) begin
                    bitcnt_next = bitcnt_reg + 4'h1;
                    // drive low for a zero, release for a one
                    if (bitcnt_reg < pskm_pkg::TX_BIT_PARITY) begin
                        data_oe_next = ~tx_byte_reg[bitcnt_reg[2:0]];
                    end else if (bitcnt_reg == pskm_pkg::TX_BIT_PARITY) begin
                        data_oe_next = ^tx_byte_reg;
                    end else if (bitcnt_reg == pskm_pkg::TX_BIT_STOP) begin
                        data_oe_next = 1'b0;
                    end else begin
                        st_next = pskm_pkg::ST_IDLE;
                        if (link_bit_reg) begin
                            nack_next = 1'b1;
                        end else if (need2_reg) begin
                            await_next = 1'b1;
                        end else begin
                            done_next = 1'b1;
                        end
                    end
                end else if (tmr_reg >= TMR_W'(TX_WAIT_CYC)) begin
                    // peripheral never clocked the byte out
                    st_next      = pskm_pkg::ST_IDLE;
                    data_oe_next = 1'b0;
                    nack_next    = 1'b1;
                end
            end
            default: begin
                st_next = pskm_pkg::ST_IDLE;
            end
        endcase
    end

    // frame engine registers
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            st_reg       <= pskm_pkg::ST_IDLE;
            tmr_reg      <= '0;
            bitcnt_reg   <= 4'h0;
            sh_reg       <= 8'h00;
            par_reg      <= 1'b0;
            tx_byte_reg  <= 8'h00;
            second_reg   <= 8'h00;
            need2_reg    <= 1'b0;
            await_reg    <= 1'b0;
            clk_oe_reg   <= 1'b0;
            data_oe_reg  <= 1'b0;
            rx_valid_reg <= 1'b0;
            rx_resp_reg  <= 1'b0;
            rx_err_reg   <= 1'b0;
            rx_abort_reg <= 1'b0;
            rx_byte_reg  <= 8'h00;
            done_reg     <= 1'b0;
            nack_reg     <= 1'b0;
        end else begin
            st_reg       <= st_next;
            tmr_reg      <= tmr_next;
            bitcnt_reg   <= bitcnt_next;
            sh_reg       <= sh_next;
            par_reg      <= par_next;
            tx_byte_reg  <= tx_byte_next;
            second_reg   <= second_next;
            need2_reg    <= need2_next;
            await_reg    <= await_next;
            clk_oe_reg   <= clk_oe_next;
            data_oe_reg  <= data_oe_next;
            rx_valid_reg <= rx_valid_next;
            rx_resp_reg  <= rx_resp_next;
            rx_err_reg   <= rx_err_next;
            rx_abort_reg <= rx_abort_next;
            rx_byte_reg  <= rx_byte_next;
            done_reg     <= done_next;
            nack_reg     <= nack_next;
        end
    end

    // ---------------- scan code and packet decoder ----------------
    logic                  ext_reg;
    logic                  ext_next;
    logic                  brk_reg;
    logic                  brk_next;
    logic [1:0]            midx_reg;
    logic [1:0]            midx_next;
    logic [7:0]            mstat_reg;
    logic [7:0]            mstat_next;
    logic [7:0]            mx_reg;
    logic [7:0]            mx_next;
    logic                  key_v_reg;
    logic                  key_v_next;
    pskm_pkg::pskm_key_t   key_reg;
    pskm_pkg::pskm_key_t   key_next;
    logic                  mv_reg;
    logic                  mv_next;
    pskm_pkg::pskm_mouse_t mouse_reg;
    pskm_pkg::pskm_mouse_t mouse_next;

    // only the reply awaited after the first byte of a two-byte command is kept from the decoders
    always_comb begin
        ext_next   = ext_reg;
        brk_next   = brk_reg;
        midx_next  = midx_reg;
        mstat_next = mstat_reg;
        mx_next    = mx_reg;
        key_v_next = 1'b0;
        key_next   = key_reg;
        mv_next    = 1'b0;
        mouse_next = mouse_reg;
        if (rx_abort_reg || rx_err_reg) begin
            // realign packets after a lost or bad frame
            midx_next = 2'h0;
            ext_next  = 1'b0;
            brk_next  = 1'b0;
        end else if (rx_valid_reg && !rx_resp_reg) begin
            if (I_MOUSE_MODE) begin
                midx_next = midx_reg + 2'h1;
                if (midx_reg == 2'h0) begin
                    mstat_next = rx_byte_reg;
                end else if (midx_reg == 2'h1) begin
                    mx_next = rx_byte_reg;
                end else begin
                    midx_next  = 2'h0;
                    mv_next    = 1'b1;
                    mouse_next.left   = mstat_reg[pskm_pkg::MS_LEFT];
                    mouse_next.right  = mstat_reg[pskm_pkg::MS_RIGHT];
                    mouse_next.x_overflow_bit = mstat_reg[pskm_pkg::MS_XV];
                    mouse_next.y_overflow_bit = mstat_reg[pskm_pkg::MS_YV];
                    mouse_next.x_move = {mstat_reg[pskm_pkg::MS_XS], mx_reg};
                    mouse_next.y_move = {mstat_reg[pskm_pkg::MS_YS], rx_byte_reg};
                end
            end else if (rx_byte_reg == pskm_pkg::CODE_EXT) begin
                ext_next = 1'b1;
            end else if (rx_byte_reg == pskm_pkg::CODE_BREAK) begin
                brk_next = 1'b1;
            end else begin
                key_v_next          = 1'b1;
                key_next.code       = rx_byte_reg;
                key_next.release_ev = brk_reg;
                key_next.extended   = ext_reg;
                ext_next            = 1'b0;
                brk_next            = 1'b0;
            end
        end
    end

    // decoder registers
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ext_reg   <= 1'b0;
            brk_reg   <= 1'b0;
            midx_reg  <= 2'h0;
            mstat_reg <= 8'h00;
            mx_reg    <= 8'h00;
            key_v_reg <= 1'b0;
            key_reg   <= '0;
            mv_reg    <= 1'b0;
            mouse_reg <= '0;
        end else begin
            ext_reg   <= ext_next;
            brk_reg   <= brk_next;
            midx_reg  <= midx_next;
            mstat_reg <= mstat_next;
            mx_reg    <= mx_next;
            key_v_reg <= key_v_next;
            key_reg   <= key_next;
            mv_reg    <= mv_next;
            mouse_reg <= mouse_next;
        end
    end

    // outputs; pins only ever pull low
    assign O_KM_CLK_OUT  = 1'b0;
    assign O_KM_DATA_OUT = 1'b0;
    assign O_KM_CLK_OE   = clk_oe_reg;
    assign O_KM_DATA_OE  = data_oe_reg;
    assign O_CMD_DONE    = done_reg;
    assign O_CMD_NACK    = nack_reg;
    assign O_RX_VALID    = rx_valid_reg;
    assign O_RX_BYTE     = rx_byte_reg;
    assign O_RX_ERROR    = rx_err_reg;
    assign O_KEY_VALID   = key_v_reg;
    assign O_KEY         = key_reg;
    assign O_MOUSE_VALID = mv_reg;
    assign O_MOUSE       = mouse_reg;
    assign O_BUSY        = (st_reg != pskm_pkg::ST_IDLE) || await_reg;
endmodule

// File: include/pskm_pkg.sv
// shared constants and carrier types for the keyboard/mouse host port
package pskm_pkg;
    // clock and times
    localparam int CLK_PERIOD_NS = 40;
    localparam int RTS_US        = 100;
    localparam int RTS_CYC       = (RTS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RX_TO_US      = 100;
    localparam int RX_TO_CYC     = (RX_TO_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TX_WAIT_US    = 15000;
    localparam int TMR_W         = 20;
    // frame layout, counted in falling clock edges
    localparam logic [3:0] BIT_FIRST_DATA = 4'h1;
    localparam logic [3:0] BIT_LAST_DATA  = 4'h8;
    localparam logic [3:0] BIT_PARITY     = 4'h9;
    localparam logic [3:0] BIT_STOP       = 4'hA;
    localparam logic [3:0] TX_BIT_PARITY  = 4'h8;
    localparam logic [3:0] TX_BIT_STOP    = 4'h9;
    localparam logic [3:0] TX_BIT_ACK     = 4'hA;
    // byte codes
    localparam logic [7:0] CODE_BREAK = 8'hF0;
    localparam logic [7:0] CODE_EXT   = 8'hE0;
    localparam logic [7:0] CMD_LEDS   = 8'hED;
    localparam logic [7:0] CMD_ECHO   = 8'hEE;
    localparam logic [7:0] CMD_RATE   = 8'hF3;
    localparam logic [7:0] CMD_RESEND = 8'hFE;
    localparam logic [7:0] CMD_RESET  = 8'hFF;
    localparam logic [7:0] RSP_ACK    = 8'hFA;
    // led byte: bit 2 caps, bit 1 num, bit 0 scroll, rest ignored
    localparam int LED_W = 3;
    // mouse status byte fields
    localparam int MS_LEFT  = 0;
    localparam int MS_RIGHT = 1;
    localparam int MS_XS    = 4;
    localparam int MS_YS    = 5;
    localparam int MS_XV    = 6;
    localparam int MS_YV    = 7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RX   = 2'b01,
        ST_RTS  = 2'b10,
        ST_TX   = 2'b11
    } pskm_state_t;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] arg;
    } pskm_cmd_t;

    typedef struct packed {
        logic       release_ev;
        logic       extended;
        logic [7:0] code;
    } pskm_key_t;

    typedef struct packed {
        logic       left;
        logic       right;
        logic       x_overflow_bit;
        logic       y_overflow_bit;
        logic [8:0] x_move;
        logic [8:0] y_move;
    } pskm_mouse_t;
endpackage

// File: tb/pskm_host_chk.sv
// assertion checker watching the host port pins
`timescale 1ns/1ns
module pskm_host_chk (
    input wire logic                  I_MCLK,
    input wire logic                  I_RESET_N,
    input wire logic                  I_INHIBIT,
    input wire logic                  O_KM_CLK_OE,
    input wire logic                  O_KM_DATA_OE,
    input wire logic                  O_CMD_READY,
    input wire logic                  O_RX_VALID,
    input wire logic [7:0]            O_RX_BYTE,
    input wire logic                  O_RX_ERROR,
    input wire logic                  O_KEY_VALID,
    input wire pskm_pkg::pskm_key_t   O_KEY,
    input wire logic                  O_MOUSE_VALID,
    input wire pskm_pkg::pskm_mouse_t O_MOUSE,
    input wire logic                  O_BUSY
);
    localparam int RTS = pskm_pkg::RTS_CYC;
    logic [31:0] hold_reg;
    logic [31:0] hold_next;
    // length of the present clock pull, for the request span
    always_comb hold_next = O_KM_CLK_OE ? hold_reg + 32'h1 : 32'h0;
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) hold_reg <= 32'h0;
        else hold_reg <= hold_next;
    end
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);
    a_idle_data_free: assert property (!O_BUSY && !$past(O_BUSY) |-> !O_KM_DATA_OE)
        else $error("data pulled while idle");
    a_idle_clk_free: assert property (!O_BUSY && !$past(O_BUSY) && !I_INHIBIT
        && !$past(I_INHIBIT) |-> !O_KM_CLK_OE) else $error("clock pulled while idle");
    a_inhibit_ready: assert property (I_INHIBIT |-> !O_CMD_READY)
        else $error("ready while inhibited");
    a_rts_span: assert property ($fell(O_KM_CLK_OE) && O_KM_DATA_OE |-> hold_reg >= RTS)
        else $error("clock released too early");
    a_data_then_rel: assert property ($rose(O_KM_DATA_OE) && O_KM_CLK_OE |=> !O_KM_CLK_OE)
        else $error("clock not released after data pull");
    a_rx_flag_excl: assert property (!(O_RX_VALID && O_RX_ERROR))
        else $error("good and bad word together");
    a_key_from_rx: assert property (O_KEY_VALID |-> $past(O_RX_VALID) && O_KEY.code == O_RX_BYTE)
        else $error("key event without matching byte");
    a_mouse_y_byte: assert property (O_MOUSE_VALID |-> $past(O_RX_VALID)
        && O_MOUSE.y_move[7:0] == O_RX_BYTE) else $error("mouse packet without y byte");
endmodule

// File: tb/pskm_dev_model.sv
// behavioural keyboard or mouse on the far side of the link
`timescale 1ns/1ns
module pskm_dev_model (
    input  wire logic i_clk_line,
    input  wire logic i_data_line,
    output logic      o_clk_pull,
    output logic      o_data_pull
);
    localparam int HALF = 32000;
    initial {o_clk_pull, o_data_pull} = 2'b00;
    // one link clock; the device moves data only in the high phase, the host after the falling edge
    task automatic pulse();
        #(HALF / 2) o_clk_pull = 1'b1;
        #(HALF) o_clk_pull = 1'b0;
        #(HALF / 2);
    endtask
    // word to the host, bad parity or cut short on request
    task automatic send(input logic [7:0] b, input logic bad, input int nb);
        logic [10:0] f;
        f = {1'b1, ~^b ^ bad, b, 1'b0};
        wait (i_clk_line && i_data_line);
        for (int i = 0; i < nb; i++) begin
            o_data_pull = ~f[i];
            pulse();
        end
        o_data_pull = 1'b0;
    endtask
    // word from the host, acknowledged on the eleventh clock
    task automatic recv(output logic [7:0] b, output logic ok);
        logic [9:0] f;
        wait (!i_clk_line);
        wait (i_clk_line && !i_data_line);
        #(HALF);
        for (int i = 0; i < 10; i++) begin
            pulse();
            f[i] = i_data_line;
        end
        b = f[7:0];
        ok = (^f[8:0]) && f[9];
        o_data_pull = 1'b1;
        pulse();
        o_data_pull = 1'b0;
    endtask
endmodule

// File: tb/pskm_host_tb_top.sv
// self-checking bench for the keyboard/mouse host port
`timescale 1ns/1ns
module pskm_host_tb_top;
    logic                  mclk, rst_n, mode, inhibit, cmd_valid, ok;
    logic                  clk_oe, data_oe, dev_clk, dev_data, rx_v, rx_e, key_v, ms_v, ready;
    logic [7:0]            rx_byte, code, b, arg, op, st, x, y;
    pskm_pkg::pskm_cmd_t   cmd;
    pskm_pkg::pskm_key_t   key, key_seen;
    pskm_pkg::pskm_mouse_t mouse, ms_seen;
    logic                  done, nack, busy;
    int                    n_errors, checks, rx_cnt, err_cnt, key_cnt, done_cnt, nack_cnt, r0;
    wire logic km_clk  = !(clk_oe || dev_clk);
    wire logic km_data = !(data_oe || dev_data);
    pskm_host #(.TX_WAIT_CYC(2000)) pskm_host_inst (
        .I_MCLK(mclk), .I_RESET_N(rst_n), .I_KM_CLK(km_clk), .I_KM_DATA(km_data),
        .O_KM_CLK_OUT(), .O_KM_CLK_OE(clk_oe), .O_KM_DATA_OUT(), .O_KM_DATA_OE(data_oe),
        .I_MOUSE_MODE(mode), .I_INHIBIT(inhibit), .I_CMD_VALID(cmd_valid), .I_CMD(cmd),
        .O_CMD_READY(ready), .O_CMD_DONE(done), .O_CMD_NACK(nack), .O_RX_VALID(rx_v),
        .O_RX_BYTE(rx_byte), .O_RX_ERROR(rx_e), .O_KEY_VALID(key_v), .O_KEY(key),
        .O_MOUSE_VALID(ms_v), .O_MOUSE(mouse), .O_BUSY(busy));
    pskm_dev_model pskm_dev_model_inst (.i_clk_line(km_clk), .i_data_line(km_data),
        .o_clk_pull(dev_clk), .o_data_pull(dev_data));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // tally of output pulses, sampled mid-cycle once they have settled
    always @(negedge mclk) begin
        if (nack === 1'b1) nack_cnt++;
        if (rx_v === 1'b1) rx_cnt++;
        if (rx_e === 1'b1) err_cnt++;
        if (done === 1'b1) done_cnt++;
        if (key_v === 1'b1) key_seen = key;
        if (key_v === 1'b1) key_cnt++;
        if (ms_v === 1'b1) ms_seen = mouse;
    end
    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask
    function automatic pskm_pkg::pskm_mouse_t exp_mouse(input logic [7:0] s, u, v);
        return {s[0], s[1], s[6], s[7], s[4], u, s[5], v};
    endfunction
    // level request held until the ready seen at a settled point is taken
    task automatic send_cmd(input logic [7:0] o, input logic [7:0] a);
        @(negedge mclk) cmd = {o, a};
        cmd_valid = 1'b1;
        for (int i = 0; i < 100 && ready !== 1'b1; i++) @(negedge mclk);
        @(negedge mclk) cmd_valid = 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog, about twice the expected run
    initial begin
        #36000000 n_errors++;
        tally_and_finish();
    end
    initial begin
        {rst_n, mode, inhibit, cmd_valid} = 4'h0;
        cmd = '0;
        void'($urandom(12));
        repeat (8) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        code = 8'h01 + 8'($urandom % 127);
        @(negedge mclk) inhibit = 1'b1;
        repeat (2) @(negedge mclk);
        fork
            pskm_dev_model_inst.send(code, 1'b0, 11);
            begin
                #200000 check("rx while inhibited", 0, rx_cnt);
                @(negedge mclk) inhibit = 1'b0;
            end
        join
        #100000 check("key make", 32'({2'b00, code}), 32'(key_seen));
        $display("test inhibit_make done");
        pskm_dev_model_inst.send(pskm_pkg::CODE_EXT, 1'b0, 11);
        pskm_dev_model_inst.send(pskm_pkg::CODE_BREAK, 1'b0, 11);
        pskm_dev_model_inst.send(code, 1'b0, 11);
        #100000 check("ext release", 32'({2'b11, code}), 32'(key_seen));
        check("key events", 2, key_cnt);
        $display("test ext_release done");
        r0 = rx_cnt;
        pskm_dev_model_inst.send(code, 1'b1, 11);
        #100000 check("parity error", 1, err_cnt);
        pskm_dev_model_inst.send(8'h55, 1'b0, 5);
        #150000 pskm_dev_model_inst.send(code, 1'b0, 11);
        #100000 check("after abandon", 32'({2'b00, code}), 32'(key_seen));
        check("dropped words", r0 + 1, rx_cnt);
        $display("test bad_words done");
        @(negedge mclk) mode = 1'b1;
        repeat (2) begin
            {st, x, y} = {8'($urandom) | 8'hC1, 8'($urandom), 8'($urandom)};
            pskm_dev_model_inst.send(st, 1'b0, 11);
            pskm_dev_model_inst.send(x, 1'b0, 11);
            pskm_dev_model_inst.send(y, 1'b0, 11);
        end
        #100000 check("mouse", 32'(exp_mouse(st, x, y)), 32'(ms_seen));
        $display("test mouse done");
        @(negedge mclk) mode = 1'b0;
        for (int n = 0; n < 2; n++) begin
            op = n ? pskm_pkg::CMD_RATE : pskm_pkg::CMD_LEDS;
            arg = 8'($urandom) | 8'hF8;
            r0 = done_cnt;
            fork
                send_cmd(op, arg);
                begin
                    pskm_dev_model_inst.recv(b, ok);
                    check("command byte", 32'(op), 32'(b));
                    check("command parity", 1, 32'(ok));
                    pskm_dev_model_inst.send(pskm_pkg::RSP_ACK, 1'b0, 11);
                    pskm_dev_model_inst.recv(b, ok);
                    check("second byte", n ? 32'(arg) : 32'(arg[2:0]), 32'(b));
                end
            join
            #100000 check("command done", r0 + 1, done_cnt);
            $display("test command %h done", op);
        end
        // echo and resend, then a reset that never clocks the byte
        for (int n = 0; n < 2; n++) begin
            op = n ? pskm_pkg::CMD_RESEND : pskm_pkg::CMD_ECHO;
            fork
                send_cmd(op, 8'h00);
                begin
                    pskm_dev_model_inst.recv(b, ok);
                    check("single byte", 32'(op), 32'(b));
                    pskm_dev_model_inst.send(n ? code : op, 1'b0, 11);
                end
            join
            #100000 check("reply byte", 32'(n ? code : op), 32'(rx_byte));
        end
        r0 = nack_cnt;
        send_cmd(pskm_pkg::CMD_RESET, 8'h00);
        #300000 check("reset nack", r0 + 1, nack_cnt);
        check("idle after nack", 0, 32'(busy));
        $display("test short commands done");
        tally_and_finish();
    end
endmodule
bind pskm_host pskm_host_chk pskm_host_chk_inst (.I_MCLK, .I_RESET_N, .I_INHIBIT,
    .O_KM_CLK_OE, .O_KM_DATA_OE, .O_CMD_READY, .O_RX_VALID, .O_RX_BYTE, .O_RX_ERROR,
    .O_KEY_VALID, .O_KEY, .O_MOUSE_VALID, .O_MOUSE, .O_BUSY);
